// ---- src/sdram_core.sv ----
/*
 * device-side command timing core of a four-bank 32-bit synchronous dram.
 * assumes a controller that honours its own spacing obligations.
 */
// Behaviour
// - a read or write command is accepted on every clock.
// - clock enable low suspends one cycle later; high resumes one later.
// - write byte mask blocks data of the same clock.
// - read byte mask floats outputs two cycles after sampling.
// - write data is captured in the write command's clock.
// - precharge of the reading bank or of all banks stops reads: outputs float after read latency cycles.
`timescale 1ns/1ps
module sdram_core (
    // clock and reset
    input  wire logic                 CORE_CLK,
    input  wire logic                 RST_N,
    input  wire logic                 CLK_EN,
    // command pins
    input  wire logic                 CKE,
    input  wire logic                 CS_N,
    input  wire logic                 RAS_N,
    input  wire logic                 CAS_N,
    input  wire logic                 WE_N,
    input  wire logic [1:0]           BA,
    input  wire logic [10:0]          ADDR,
    input  wire logic [3:0]           DQM,
    // data pins
    input  wire logic [31:0]          DQ_IN,
    output logic      [31:0]          DQ_OUT,
    output logic      [3:0]           DQ_OE_N,
    // status
    output logic                      SUSPENDED,
    output logic      [2:0]           READ_LATENCY_SETTING
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10
    } burst_t;

    burst_t      burst_reg;
    logic [2:0]  lat_reg;
    logic [2:0]  bl_reg;
    logic [8:0]  left_reg;
    logic [1:0]  bank_reg;
    logic [7:0]  col_reg;
    logic        ap_reg;
    logic [10:0] row_reg [4];
    logic        cke_reg;
    logic [2:0]  drv_pipe_reg;
    logic [31:0] rd_pipe_reg [3];
    logic [31:0] mem_reg [sdram_timing_pkg::MEM_DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // command decode; cke sampled a cycle earlier gates the clock
    wire        run   = CLK_EN && cke_reg;
    wire [3:0]  cmd   = {CS_N, RAS_N, CAS_N, WE_N};
    wire        c_rd  = cmd == sdram_timing_pkg::CMD_READ;
    wire        c_wr  = cmd == sdram_timing_pkg::CMD_WRITE;
    wire        c_pre = cmd == sdram_timing_pkg::CMD_PRE;
    wire        c_act = cmd == sdram_timing_pkg::CMD_ACT;
    wire        c_mrs = cmd == sdram_timing_pkg::CMD_MRS;
    wire        c_stp = cmd == sdram_timing_pkg::CMD_STOP;
    wire        pre_hit = c_pre && (ADDR[sdram_timing_pkg::AP_BIT]
                          || BA == bank_reg);
    wire [8:0]  bl_len = (bl_reg == sdram_timing_pkg::BL_ONE)   ? 9'h001 :
                         (bl_reg == sdram_timing_pkg::BL_TWO)   ? 9'h002 :
                         (bl_reg == sdram_timing_pkg::BL_FOUR)  ? 9'h004 :
                         (bl_reg == sdram_timing_pkg::BL_EIGHT) ? 9'h008 :
                         sdram_timing_pkg::BURST_PAGE_LEN;
    // column in flight this clock
    wire        new_col = c_rd || c_wr;
    wire [1:0]  cur_bank = new_col ? BA : bank_reg;
    wire [7:0]  cur_col  = new_col ? ADDR[7:0] : col_reg;
    wire [5:0]  idx = {cur_bank, row_reg[cur_bank][1:0], cur_col[1:0]};
    wire        wr_now  = c_wr || (burst_reg == ST_WRITE && !c_stp
                          && !c_pre && !c_rd && !c_mrs);
    wire        rd_now  = c_rd || (burst_reg == ST_READ && !c_stp
                          && !pre_hit && !c_wr);
    // drive pipeline tap per latency; precharge cut follows it
    wire        drive_tap = (lat_reg == sdram_timing_pkg::LAT_TWO)
                          ? drv_pipe_reg[sdram_timing_pkg::RELEASE_LAT2-1]
                          : drv_pipe_reg[sdram_timing_pkg::RELEASE_LAT3-1];
    // data taps line up with the drive taps, one stage per latency clock
    wire [31:0] rd_tap = (lat_reg == sdram_timing_pkg::LAT_TWO)
                          ? rd_pipe_reg[sdram_timing_pkg::RELEASE_LAT2-1]
                          : rd_pipe_reg[sdram_timing_pkg::RELEASE_LAT3-1];
    wire [7:0]  lane1_old = mem_reg[idx][15:8];
    wire [31:0] wr_word;
    wire [31:0] q_word;
    wire [3:0]  oe_word;

    ////////////////////////////////////////////////////////////////////////
    // one lane per byte; mask latency 0 on writes, 2 on reads
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            dq_lane u_lane (
                .clk       (CORE_CLK),
                .rst_n     (RST_N),
                .ce        (run),
                .drive_req (drive_tap),
                .mask_in   (DQM[g]),
                .rd_byte   (rd_tap[8*g +: 8]),
                .q_out     (q_word[8*g +: 8]),
                .q_oe_n    (oe_word[g]),
                .wr_en     (wr_now),
                .old_byte  (mem_reg[idx][8*g +: 8]),
                .d_in      (DQ_IN[8*g +: 8]),
                .wr_byte   (wr_word[8*g +: 8])
            );
        end
    endgenerate

    assign DQ_OUT  = q_word;
    assign DQ_OE_N = oe_word;

    ////////////////////////////////////////////////////////////////////////
    // clock enable sampled on every edge with CLK_EN high, one-cycle entry and exit
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            cke_reg   <= 1'b1;
            SUSPENDED <= 1'b0;
        end else if (CLK_EN) begin
            cke_reg   <= CKE;
            SUSPENDED <= !CKE;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            lat_reg              <= sdram_timing_pkg::RESET_LAT;
            bl_reg               <= sdram_timing_pkg::BL_ONE;
            READ_LATENCY_SETTING <= sdram_timing_pkg::RESET_LAT;
        end else if (run && c_mrs) begin
            lat_reg <= ADDR[sdram_timing_pkg::MODE_LAT_LSB +: 3];
            bl_reg  <= ADDR[sdram_timing_pkg::MODE_BL_LSB +: 3];
            READ_LATENCY_SETTING <= ADDR[sdram_timing_pkg::MODE_LAT_LSB +: 3];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (run && c_act) begin
            row_reg[BA] <= ADDR;
        end
        if (run && wr_now) begin
            mem_reg[idx] <= wr_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // burst sequencer
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            burst_reg <= ST_IDLE;
            left_reg  <= 9'h000;
            bank_reg  <= 2'h0;
            col_reg   <= 8'h00;
            ap_reg    <= 1'b0;
        end else if (run) begin
            if (new_col) begin
                burst_reg <= (bl_len == 9'h001) ? ST_IDLE :
                             (c_rd ? ST_READ : ST_WRITE);
                left_reg  <= bl_len - 9'h001;
                bank_reg  <= BA;
                col_reg   <= ADDR[7:0] + 8'h01;
                ap_reg    <= ADDR[sdram_timing_pkg::AP_BIT];
            end else if (c_stp || pre_hit || c_mrs) begin
                burst_reg <= ST_IDLE;
            end else if (burst_reg != ST_IDLE) begin
                col_reg  <= col_reg + 8'h01;
                left_reg <= left_reg - 9'h001;
                if (left_reg == 9'h001) begin
                    burst_reg <= ST_IDLE;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            drv_pipe_reg <= 3'h0;
        end else if (run) begin
            drv_pipe_reg <= {drv_pipe_reg[1:0], rd_now};
            rd_pipe_reg[0] <= mem_reg[idx];
            rd_pipe_reg[1] <= rd_pipe_reg[0];
            rd_pipe_reg[2] <= rd_pipe_reg[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    cke_lat_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && !CKE && !$past(CKE) && $past(CLK_EN)) |=> SUSPENDED)
        else $error("clock enable low not seen one cycle later");
    rd_mask_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (run && DQM[0]) ##1 run ##1 run
        |=> DQ_OE_N[0])
        else $error("read mask did not float lane after two cycles");
    wr_mask_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (run && wr_now && DQM[1])
        |=> mem_reg[$past(idx)][15:8] == $past(lane1_old))
        else $error("masked write byte changed");
    wr_data_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (run && c_wr && DQM == 4'h0) |=> mem_reg[$past(idx)] == $past(DQ_IN))
        else $error("write data not captured with command");
    col_cmd_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (run && c_rd) ##1 (run && c_rd) |=> drv_pipe_reg[1:0] == 2'h3)
        else $error("back to back read not accepted");
    pre_rel_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (run && pre_hit && lat_reg == sdram_timing_pkg::LAT_TWO
         && burst_reg == ST_READ) ##1 run ##1 run
        |=> DQ_OE_N == 4'hf)
        else $error("outputs not released after precharge");
endmodule : sdram_core

// ---- src/sdram_timing_pkg.sv ----
/*
 * constants for the sdram command timing core: command codes, latencies,
 * burst lengths, widths.
 * assumes a 100 MHz core clock; no registers reached by software.
 */
package sdram_timing_pkg;
    localparam int unsigned CLK_PERIOD_PS   = 10000;
    localparam int unsigned DATA_W          = 32;
    localparam int unsigned MASK_W          = 4;
    localparam int unsigned BANK_W          = 2;
    localparam int unsigned ROW_W           = 11;
    localparam int unsigned COL_W           = 8;
    localparam int unsigned ADDR_W          = 11;
    localparam int unsigned MEM_DEPTH       = 64;
    localparam int unsigned MEM_IDX_W       = 6;
    // read data / mask / clock enable pipeline depths
    localparam int unsigned READ_MASK_LAT   = 2;
    localparam int unsigned RELEASE_LAT3    = 3;
    localparam int unsigned RELEASE_LAT2    = 2;
    localparam int unsigned CKE_LAT         = 1;
    localparam int unsigned PIPE_W          = 3;
    // mode word fields
    localparam int unsigned MODE_LAT_LSB    = 4;
    localparam int unsigned MODE_BL_LSB     = 0;
    localparam logic [2:0]  LAT_TWO         = 3'h2;
    localparam logic [2:0]  LAT_THREE       = 3'h3;
    localparam logic [2:0]  BL_ONE          = 3'h0;
    localparam logic [2:0]  BL_TWO          = 3'h1;
    localparam logic [2:0]  BL_FOUR         = 3'h2;
    localparam logic [2:0]  BL_EIGHT        = 3'h3;
    localparam logic [2:0]  BL_PAGE         = 3'h7;
    localparam logic [8:0]  BURST_PAGE_LEN  = 9'h100;
    localparam logic [2:0]  RESET_LAT       = 3'h3;
    // {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0] {
        CMD_MRS   = 4'h0,
        CMD_REF   = 4'h1,
        CMD_PRE   = 4'h2,
        CMD_ACT   = 4'h3,
        CMD_WRITE = 4'h4,
        CMD_READ  = 4'h5,
        CMD_STOP  = 4'h6,
        CMD_NOP   = 4'h7
    } cmd_t;
    localparam int unsigned AP_BIT = 10;
endpackage : sdram_timing_pkg

// ---- src/dq_lane.sv ----
/*
 * one byte lane of the data bus: read output register with its own
 * mask pipeline and output enable, and masked write capture.
 * assumes the core supplies aligned read data and a drive request.
 */
`timescale 1ns/1ps
module dq_lane (
    // clock and control
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // read side
    input  wire logic       drive_req,
    input  wire logic       mask_in,
    input  wire logic [7:0] rd_byte,
    output logic      [7:0] q_out,
    output logic            q_oe_n,
    // write side
    input  wire logic       wr_en,
    input  wire logic [7:0] old_byte,
    input  wire logic [7:0] d_in,
    output wire logic [7:0] wr_byte
);
    logic [1:0] mask_pipe_reg;
    wire        lane_on = drive_req && !mask_pipe_reg[1];

    // masked byte keeps its stored value, same clock
    assign wr_byte = (wr_en && !mask_in) ? d_in : old_byte;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mask_pipe_reg <= 2'h0;
            q_out         <= 8'h00;
            q_oe_n        <= 1'b1;
        end else if (ce) begin
            mask_pipe_reg <= {mask_pipe_reg[0], mask_in};
            q_out         <= rd_byte;
            q_oe_n        <= !lane_on;
        end
    end
endmodule : dq_lane

// ---- verif/sdram_ctl_model.sv ----
/* controller model: drives command, mask and write-data pins.
   assumes the device samples its pins on the rising clock edge. */
`timescale 1ns/1ps
module sdram_ctl_model #(
    parameter int WAKE = 10000
) (
    // clock
    input  wire logic        clk,
    // pins toward the device
    output logic             cke,
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic [10:0]      addr,
    output logic [3:0]       dqm,
    output logic [31:0]      dq
);
    initial begin
        cke = 1'b1;
        {cs_n, ras_n, cas_n, we_n} = sdram_timing_pkg::CMD_NOP;
        addr = 11'h000;
        dqm = 4'h0;
        dq = 32'h0;
    end
    task automatic issue(input sdram_timing_pkg::cmd_t c,
                         input logic [10:0] a, input logic [31:0] d,
                         input logic [3:0] m);
        @(negedge clk);
        {cs_n, ras_n, cas_n, we_n} = c;
        addr = a;
        dq = d;
        dqm = m;
    endtask : issue
    // released data line toggles every idle cycle
    task automatic idle(input int n, input logic [3:0] m);
        repeat (n) begin
            @(negedge clk);
            {cs_n, ras_n, cas_n, we_n} = sdram_timing_pkg::CMD_NOP;
            dq = ~dq;
            dqm = m;
        end
    endtask : idle
    task automatic wake();
        idle(WAKE, 4'h0);
        repeat (2) begin
            issue(sdram_timing_pkg::CMD_REF, 11'h000, ~dq, 4'h0);
            idle(7, 4'h0);
        end
    endtask : wake
    task automatic mode(input logic [10:0] a);
        issue(sdram_timing_pkg::CMD_MRS, a, ~dq, 4'h0);
        idle(2, 4'h0);
    endtask : mode
    task automatic set_cke(input logic v);
        @(negedge clk);
        cke = v;
    endtask : set_cke
endmodule : sdram_ctl_model

// ---- verif/sdram_command_timing_tb_top.sv ----
/* self-checking bench for the sdram timing core.
   assumes the controller model on the command and data pins. */
`timescale 1ns/1ps
module sdram_command_timing_tb_top;
    localparam sdram_timing_pkg::cmd_t C_ACT = sdram_timing_pkg::CMD_ACT;
    localparam sdram_timing_pkg::cmd_t C_WR  = sdram_timing_pkg::CMD_WRITE;
    localparam sdram_timing_pkg::cmd_t C_RD  = sdram_timing_pkg::CMD_READ;
    localparam sdram_timing_pkg::cmd_t C_PRE = sdram_timing_pkg::CMD_PRE;
    localparam sdram_timing_pkg::cmd_t C_NOP = sdram_timing_pkg::CMD_NOP;
    localparam sdram_timing_pkg::cmd_t C_STP = sdram_timing_pkg::CMD_STOP;
    logic        clk = 1'b0;
    logic        ce = 1'b1;
    logic        rst_n = 1'b0;
    logic        cke, cs_n, ras_n, cas_n, we_n, susp;
    logic [10:0] addr;
    logic [3:0]  dqm, oe_n;
    logic [31:0] dq_in, dq_out;
    logic [2:0]  lat;
    int          fail_count = 0;
    int          comparisons = 0;
    int          cycles = 0;

    always #5 clk = ~clk;
    sdram_ctl_model ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .addr(addr), .dqm(dqm), .dq(dq_in));
    sdram_core dut (.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(ce),
        .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n),
        .WE_N(we_n), .BA(2'h0), .ADDR(addr), .DQM(dqm), .DQ_IN(dq_in),
        .DQ_OUT(dq_out), .DQ_OE_N(oe_n), .SUSPENDED(susp),
        .READ_LATENCY_SETTING(lat));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic t_reset();
        check("lat", 32'(lat), 32'(sdram_timing_pkg::RESET_LAT));
        check("oe", 32'(oe_n), 32'hf);
        check("susp", 32'(susp), 32'h0);
        check("dq reset", dq_out, 32'h0);
    endtask : t_reset
    task automatic t_rw();
        ctl.issue(C_ACT, 11'h000, 32'h0, 4'h0);
        ctl.idle(2, 4'h0);
        ctl.issue(C_WR, 11'h000, 32'h11223344, 4'h0);
        ctl.issue(C_WR, 11'h001, 32'h55667788, 4'h0);
        ctl.issue(C_WR, 11'h001, 32'haabbccdd, 4'h2);
        ctl.issue(C_RD, 11'h000, 32'h0, 4'h0);
        ctl.issue(C_RD, 11'h001, 32'h0, 4'h0);
        ctl.idle(3, 4'h0);
        check("oe lat3", 32'(oe_n), 32'h0);
        check("col0", dq_out, 32'h11223344);
        ctl.idle(1, 4'h0);
        check("col1", dq_out, 32'haabb77dd);
        ctl.idle(1, 4'h0);
        check("oe end", 32'(oe_n), 32'hf);
    endtask : t_rw
    task automatic t_mask();
        ctl.mode(11'h022);
        check("lat", 32'(lat), 32'(sdram_timing_pkg::LAT_TWO));
        ctl.issue(C_RD, 11'h000, 32'h0, 4'h0);
        ctl.idle(1, 4'h1);
        ctl.idle(2, 4'h0);
        check("oe lat2", 32'(oe_n), 32'h0);
        check("lat2 data", dq_out, 32'h11223344);
        ctl.idle(1, 4'h0);
        check("oe masked", 32'(oe_n), 32'h1);
        ctl.idle(1, 4'h0);
        check("oe unmasked", 32'(oe_n), 32'h0);
        ctl.idle(2, 4'h0);
        check("oe burst end", 32'(oe_n), 32'hf);
    endtask : t_mask
    task automatic t_pre();
        ctl.issue(C_RD, 11'h000, 32'h0, 4'h0);
        ctl.issue(C_PRE, 11'h000, 32'h0, 4'h0);
        ctl.idle(2, 4'h0);
        check("oe held", 32'(oe_n), 32'h0);
        ctl.idle(1, 4'h0);
        check("oe released", 32'(oe_n), 32'hf);
        ctl.issue(C_ACT, 11'h000, 32'h0, 4'h0);
    endtask : t_pre
    task automatic t_stop();
        ctl.idle(2, 4'h0);
        ctl.issue(C_WR, 11'h002, 32'h01020304, 4'h0);
        ctl.issue(C_NOP, 11'h000, 32'h05060708, 4'h0);
        ctl.issue(C_STP, 11'h000, 32'h0a0b0c0d, 4'h0);
        ctl.issue(C_RD, 11'h000, 32'h0, 4'h0);
        ctl.idle(3, 4'h0);
        check("stop kept", dq_out, 32'h11223344);
        ctl.idle(2, 4'h0);
        check("burst beat", dq_out, 32'h01020304);
        ctl.idle(1, 4'h0);
        check("burst next", dq_out, 32'h05060708);
    endtask : t_stop
    task automatic t_cke();
        ctl.set_cke(1'b0);
        check("susp early", 32'(susp), 32'h0);
        ctl.idle(1, 4'h0);
        check("susp", 32'(susp), 32'h1);
        ctl.set_cke(1'b1);
        check("resume early", 32'(susp), 32'h1);
        ctl.idle(1, 4'h0);
        check("resumed", 32'(susp), 32'h0);
    endtask : t_cke
    task automatic t_freeze();
        @(negedge clk);
        ce = 1'b0;
        ctl.set_cke(1'b0);
        ctl.idle(2, 4'h0);
        check("frozen susp", 32'(susp), 32'h0);
        ctl.set_cke(1'b1);
        @(negedge clk);
        ce = 1'b1;
    endtask : t_freeze
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        t_reset();
        rst_n = 1'b1;
        ctl.wake();
        t_rw();
        t_mask();
        t_pre();
        t_stop();
        t_cke();
        t_freeze();
        summarize();
    end
endmodule : sdram_command_timing_tb_top
